// ### inc/wave_notify_pkg.sv
// register map, reset values and field layout of the waveform pace and notification block
//
// Functional notes
// - Two dividers each make a pace clock at the unit clock divided by 2 to the power d plus 1.
// - Divider one takes its 4-bit exponent from bits 3:0 of the divider register, reset zero.
// - A clear select bit runs its pad on divider one, a set bit on divider two.
// - Suspend pauses a pad, and its clear restarts it at once unless a sync mode is on.
// - With frame sync on, after suspend clears, the pad restarts on each falling frame-valid edge.
// - With strobe sync on, after suspend clears, the pad restarts on each rising strobe edge.
// - A set reset bit halts the pad and clears its counters until software clears the bit.
// - A set notify type bit raises a notification when that pad's waveform completes.
// - A clear notify type bit raises a notification on the pad's next edge of chosen polarity.
// - Edge bits for pads 0-7 and 8-11 pick rising edges when set and falling edges when clear.
// - A set mask bit blocks wake-up from its pad; masks reset to 0x0f and 0xff.
// - Each pad has a status flag set by its notification and cleared by writing a one.
// - A period has 1 to 5 nonzero subperiods counted in ticks of the selected pace clock.
// - Bits 3:0 of the pair config register enable waveform generation per pad pair.
package wave_notify_pkg;
   // ---------------------------------------------------------------
   // register indices (word address; byte address is four times this)
   // ---------------------------------------------------------------
   localparam logic [12:0] IDX_PAIR_CONFIG = 13'h10b0;
   localparam logic [12:0] IDX_CLOCK_DIVIDER = 13'h10b2;
   localparam logic [12:0] IDX_DIVIDER_SELECT = 13'h10b3;
   localparam logic [12:0] IDX_FRAME_END_SYNC = 13'h10b4;
   localparam logic [12:0] IDX_CHANNEL_RESET = 13'h10b5;
   localparam logic [12:0] IDX_CHANNEL_SUSPEND = 13'h10b6;
   localparam logic [12:0] IDX_SOURCE_TYPE = 13'h10b8;
   localparam logic [12:0] IDX_EDGE_UPPER = 13'h10b9;
   localparam logic [12:0] IDX_EDGE_LOWER = 13'h10ba;
   localparam logic [12:0] IDX_MASK_UPPER = 13'h10bb;
   localparam logic [12:0] IDX_MASK_LOWER = 13'h10bc;
   localparam logic [12:0] IDX_STROBE_SYNC = 13'h10bd;
   localparam logic [12:0] IDX_FLAGS_UPPER = 13'h10be;
   localparam logic [12:0] IDX_FLAGS_LOWER = 13'h10bf;
   // ---------------------------------------------------------------
   // field layout and reset values
   // ---------------------------------------------------------------
   localparam int DIV1_LSB = 0;
   localparam int DIV2_LSB = 4;
   localparam int DIV_W = 4;
   localparam int PAIR_EN_W = 4;
   localparam int WAVE_PADS = 8;
   localparam int UPPER_PADS = 4;
   localparam int ALL_PADS = 12;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [3:0] RST_MASK_UPPER = 4'hf;
   localparam logic [7:0] RST_MASK_LOWER = 8'hff;
   localparam int SUBPERIOD_MIN = 1;
   localparam int SUBPERIOD_MAX = 5;
endpackage : wave_notify_pkg

// ### core/gpio_waveform_notify_ctrl.sv
// pace dividers, per-pad start control and notification flags with Avalon-MM slave
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/100ps
module gpio_waveform_notify_ctrl #(
   parameter int ADDR_W = 13
) (
   input wire logic mclk, // unit clock, 200 MHz
   input wire logic rst, // synchronous reset, active high
   input wire logic ce, // clock enable, freezes all state when low
   input wire logic [ADDR_W-1:0] avs_address, // word address
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [31:0] avs_writedata, // write data, low byte used
   input wire logic [3:0] avs_byteenable, // byte lanes
   output logic [31:0] avs_readdata, // read data
   output logic avs_waitrequest, // stall
   input wire logic frame_valid, // frame-valid pin, async
   input wire logic flash_strobe, // flash strobe pin, async
   input wire logic [11:0] pad_in, // pad levels, async
   input wire logic [7:0] wave_done, // end of waveform pulse from generator
   output logic [1:0] pace_tick, // one-cycle tick of each divider
   output logic [1:0] pace_clk, // square pace clock of each divider
   output logic [7:0] pad_tick, // tick of the divider chosen per pad
   output logic [7:0] wave_run, // pad may generate
   output logic [7:0] wave_start, // one-cycle restart of the pad waveform
   output logic [7:0] wave_clear, // hold pad counters cleared
   output logic wake_irq // microcontroller wake request
);
   initial begin
      if (ADDR_W < 13) begin
         $error("ADDR_W too small for the register map");
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [3:0] pair_config;
   logic [7:0] clock_divider;
   logic [7:0] divider_select;
   logic [7:0] frame_end_sync;
   logic [7:0] channel_reset;
   logic [7:0] channel_suspend;
   logic [7:0] source_type;
   logic [11:0] edge_sel;
   logic [11:0] mask;
   logic [7:0] strobe_sync;
   logic [11:0] flags;
   logic ack;
   logic req;
   logic wr_go;
   logic [7:0] wbyte;
   logic [12:0] idx;

   // ---------------------------------------------------------------
   // bus slave
   // ---------------------------------------------------------------
   // one wait cycle per access; the access completes on the second edge
   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack;
   assign wr_go = avs_write & ack & ce & avs_byteenable[0];
   assign wbyte = avs_writedata[7:0];
   assign idx = avs_address[12:0];

   // wait-state tracker
   always_ff @(posedge mclk) begin
      if (rst) begin
         ack <= 1'b0;
      end else if (ce) begin
         ack <= req & ~ack;
      end
   end

   // control register writes
   always_ff @(posedge mclk) begin
      if (rst) begin
         pair_config <= 4'h0;
         clock_divider <= wave_notify_pkg::RST_ZERO;
         divider_select <= wave_notify_pkg::RST_ZERO;
         frame_end_sync <= wave_notify_pkg::RST_ZERO;
         channel_reset <= wave_notify_pkg::RST_ZERO;
         channel_suspend <= wave_notify_pkg::RST_ZERO;
         source_type <= wave_notify_pkg::RST_ZERO;
         edge_sel <= 12'h000;
         mask <= {wave_notify_pkg::RST_MASK_UPPER, wave_notify_pkg::RST_MASK_LOWER};
         strobe_sync <= wave_notify_pkg::RST_ZERO;
      end else if (wr_go) begin
         case (idx)
            wave_notify_pkg::IDX_PAIR_CONFIG: pair_config <= wbyte[3:0];
            wave_notify_pkg::IDX_CLOCK_DIVIDER: clock_divider <= wbyte;
            wave_notify_pkg::IDX_DIVIDER_SELECT: divider_select <= wbyte;
            wave_notify_pkg::IDX_FRAME_END_SYNC: frame_end_sync <= wbyte;
            wave_notify_pkg::IDX_CHANNEL_RESET: channel_reset <= wbyte;
            wave_notify_pkg::IDX_CHANNEL_SUSPEND: channel_suspend <= wbyte;
            wave_notify_pkg::IDX_SOURCE_TYPE: source_type <= wbyte;
            wave_notify_pkg::IDX_EDGE_UPPER: edge_sel[11:8] <= wbyte[3:0];
            wave_notify_pkg::IDX_EDGE_LOWER: edge_sel[7:0] <= wbyte;
            wave_notify_pkg::IDX_MASK_UPPER: mask[11:8] <= wbyte[3:0];
            wave_notify_pkg::IDX_MASK_LOWER: mask[7:0] <= wbyte;
            wave_notify_pkg::IDX_STROBE_SYNC: strobe_sync <= wbyte;
            default: ;
         endcase
      end
   end

   // read data captured in the wait cycle, stands when waitrequest drops
   always_ff @(posedge mclk) begin
      if (rst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (ce && avs_read && !ack) begin
         case (idx)
            wave_notify_pkg::IDX_PAIR_CONFIG: avs_readdata <= {28'h0, pair_config};
            wave_notify_pkg::IDX_CLOCK_DIVIDER: avs_readdata <= {24'h0, clock_divider};
            wave_notify_pkg::IDX_DIVIDER_SELECT: avs_readdata <= {24'h0, divider_select};
            wave_notify_pkg::IDX_FRAME_END_SYNC: avs_readdata <= {24'h0, frame_end_sync};
            wave_notify_pkg::IDX_CHANNEL_RESET: avs_readdata <= {24'h0, channel_reset};
            wave_notify_pkg::IDX_CHANNEL_SUSPEND: avs_readdata <= {24'h0, channel_suspend};
            wave_notify_pkg::IDX_SOURCE_TYPE: avs_readdata <= {24'h0, source_type};
            wave_notify_pkg::IDX_EDGE_UPPER: avs_readdata <= {28'h0, edge_sel[11:8]};
            wave_notify_pkg::IDX_EDGE_LOWER: avs_readdata <= {24'h0, edge_sel[7:0]};
            wave_notify_pkg::IDX_MASK_UPPER: avs_readdata <= {28'h0, mask[11:8]};
            wave_notify_pkg::IDX_MASK_LOWER: avs_readdata <= {24'h0, mask[7:0]};
            wave_notify_pkg::IDX_STROBE_SYNC: avs_readdata <= {24'h0, strobe_sync};
            wave_notify_pkg::IDX_FLAGS_UPPER: avs_readdata <= {28'h0, flags[11:8]};
            wave_notify_pkg::IDX_FLAGS_LOWER: avs_readdata <= {24'h0, flags[7:0]};
            default: avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // pin synchronisers and edge detect
   // ---------------------------------------------------------------
   logic [13:0] sync1;
   logic [13:0] sync2;
   logic [13:0] sync_prev;
   logic fv_fall;
   logic strobe_rise;
   logic [11:0] pad_rise;
   logic [11:0] pad_fall;

   // two flops, then one more stage for edge history
   always_ff @(posedge mclk) begin
      if (rst) begin
         sync1 <= 14'h0000;
         sync2 <= 14'h0000;
         sync_prev <= 14'h0000;
      end else if (ce) begin
         sync1 <= {flash_strobe, frame_valid, pad_in};
         sync2 <= sync1;
         sync_prev <= sync2;
      end
   end

   assign fv_fall = sync_prev[12] & ~sync2[12];
   assign strobe_rise = sync2[13] & ~sync_prev[13];
   assign pad_rise = sync2[11:0] & ~sync_prev[11:0];
   assign pad_fall = ~sync2[11:0] & sync_prev[11:0];

   // ---------------------------------------------------------------
   // pace dividers
   // ---------------------------------------------------------------
   logic [15:0] div_cnt [2];
   logic [16:0] div_span [2];
   logic [3:0] div_exp [2];

   assign div_exp[0] = clock_divider[wave_notify_pkg::DIV1_LSB +: wave_notify_pkg::DIV_W];
   assign div_exp[1] = clock_divider[wave_notify_pkg::DIV2_LSB +: wave_notify_pkg::DIV_W];

   // free counter per divider; tick every 2^(d+1) cycles
   for (genvar k = 0; k < 2; k++) begin : g_div
      assign div_span[k] = (17'h00002 << div_exp[k]) - 17'h00001;
      always_ff @(posedge mclk) begin
         if (rst) begin
            div_cnt[k] <= 16'h0000;
         end else if (ce) begin
            div_cnt[k] <= (div_cnt[k] >= div_span[k][15:0]) ? 16'h0000 : div_cnt[k] + 16'h0001;
         end
      end
      assign pace_tick[k] = (div_cnt[k] == div_span[k][15:0]);
      assign pace_clk[k] = div_cnt[k][div_exp[k]];
   end

   // ---------------------------------------------------------------
   // per-pad start control
   // ---------------------------------------------------------------
   logic [7:0] allowed;
   logic [7:0] allowed_q;
   logic [7:0] gate;
   logic [7:0] any_sync;
   logic [7:0] start_evt;

   // subperiod counting is done downstream on pad_tick
   for (genvar b = 0; b < 8; b++) begin : g_pad
      assign pad_tick[b] = divider_select[b] ? pace_tick[1] : pace_tick[0];
      assign allowed[b] = ~channel_suspend[b] & ~channel_reset[b] & pair_config[b/2];
      assign any_sync[b] = frame_end_sync[b] | strobe_sync[b];
      assign start_evt[b] = allowed[b] & (any_sync[b]
         ? ((frame_end_sync[b] & fv_fall) | (strobe_sync[b] & strobe_rise))
         : ~allowed_q[b]);
   end

   // start gate held until suspend, reset or disable
   always_ff @(posedge mclk) begin
      if (rst) begin
         allowed_q <= 8'h00;
         gate <= 8'h00;
      end else if (ce) begin
         allowed_q <= allowed;
         gate <= (gate | start_evt) & allowed;
      end
   end

   assign wave_start = start_evt & {8{ce}};
   assign wave_run = gate & allowed;
   assign wave_clear = channel_reset;

   // ---------------------------------------------------------------
   // notification flags and wake
   // ---------------------------------------------------------------
   logic [11:0] edge_evt;
   logic [11:0] notify_evt;
   logic [11:0] clr_mask;

   assign edge_evt = (edge_sel & pad_rise) | (~edge_sel & pad_fall);
   assign notify_evt[7:0] = (source_type & wave_done) | (~source_type & edge_evt[7:0]);
   assign notify_evt[11:8] = edge_evt[11:8];
   assign clr_mask = !wr_go ? 12'h000
      : (idx == wave_notify_pkg::IDX_FLAGS_LOWER) ? {4'h0, wbyte}
      : (idx == wave_notify_pkg::IDX_FLAGS_UPPER) ? {wbyte[3:0], 8'h00} : 12'h000;

   // sticky flags; an event in the clearing cycle wins
   always_ff @(posedge mclk) begin
      if (rst) begin
         flags <= 12'h000;
      end else if (ce) begin
         flags <= (flags & ~clr_mask) | notify_evt;
      end
   end

   assign wake_irq = |(flags & ~mask);

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   AST_MASK_RESET: assert property (@(posedge mclk) $past(rst) && !rst |-> mask == 12'hfff)
      else $error("masks not all set after reset");

   AST_DIV_PERIOD: assert property (@(posedge mclk) disable iff (rst)
      (ce && div_exp[0] == 4'h0 && pace_tick[0]) ##1 (ce && div_exp[0] == 4'h0)
      |=> pace_tick[0])
      else $error("divider one period wrong for d zero");

   AST_DIV_SELECT: assert property (@(posedge mclk) disable iff (rst)
      divider_select[1] && pace_tick[1] && !pace_tick[0] |-> pad_tick[1])
      else $error("pad tick not from divider two");

   AST_SUSPEND_HALT: assert property (@(posedge mclk) disable iff (rst)
      channel_suspend[0] |-> !wave_run[0] && !wave_start[0])
      else $error("suspended pad still runs");

   AST_RESET_HALT: assert property (@(posedge mclk) disable iff (rst)
      channel_reset[2] |-> wave_clear[2] && !wave_run[2] ##1 (channel_reset[2] || !wave_run[2]))
      else $error("reset pad not halted");

   AST_FRAME_SYNC: assert property (@(posedge mclk) disable iff (rst)
      wave_start[0] && frame_end_sync[0] && !strobe_sync[0] |-> fv_fall)
      else $error("frame-synced start without frame end");

   AST_STROBE_SYNC: assert property (@(posedge mclk) disable iff (rst)
      wave_start[0] && strobe_sync[0] && !frame_end_sync[0] |-> strobe_rise)
      else $error("strobe-synced start without strobe edge");

   AST_DONE_FLAG: assert property (@(posedge mclk) disable iff (rst)
      ce && source_type[0] && wave_done[0] |=> flags[0])
      else $error("completion did not set flag");

   AST_EDGE_FLAG: assert property (@(posedge mclk) disable iff (rst)
      ce && edge_sel[8] && pad_rise[8] |=> flags[8])
      else $error("rising edge did not set flag");

   AST_W1C: assert property (@(posedge mclk) disable iff (rst)
      flags[1] && clr_mask[1] && !notify_evt[1] && ce |=> !flags[1])
      else $error("write one did not clear flag");
   AST_WAKE: assert property (@(posedge mclk) disable iff (rst)
      flags[0] && !mask[0] |-> wake_irq)
      else $error("wake missing for unmasked flag");

   // ---------------------------------------------------------------
   // further checks on dividers, bus, start control and flags
   // ---------------------------------------------------------------
   AST_DIV2_PERIOD: assert property (@(posedge mclk) disable iff (rst)
      (ce && div_exp[1] == 4'h0 && pace_tick[1]) ##1 (ce && div_exp[1] == 4'h0)
      |=> pace_tick[1])
      else $error("divider two period wrong for d zero");

   AST_TICK_SINGLE: assert property (@(posedge mclk)
      ce && pace_tick[0] |=> !pace_tick[0])
      else $error("divider one tick too long");

   AST_TICK2_SINGLE: assert property (@(posedge mclk)
      ce && pace_tick[1] |=> !pace_tick[1])
      else $error("divider two tick too long");

   AST_SELECT_ONE: assert property (@(posedge mclk)
      !divider_select[1] |-> pad_tick[1] == pace_tick[0])
      else $error("pad tick not from divider one");

   AST_PAIR_OFF: assert property (@(posedge mclk)
      !pair_config[0] |-> !wave_run[1] && !wave_start[1])
      else $error("disabled pair still runs");

   AST_RUN_GATE: assert property (@(posedge mclk)
      wave_run[0] |-> pair_config[0] && !channel_reset[0])
      else $error("pad runs while off or reset");

   AST_SUSPEND_PAD1: assert property (@(posedge mclk)
      channel_suspend[1] |-> !wave_run[1])
      else $error("suspended pad one runs");

   AST_RESET_CLEAR: assert property (@(posedge mclk)
      channel_reset[0] |-> wave_clear[0] && !wave_start[0])
      else $error("reset pad not held clear");

   AST_CLEAR_LEVEL: assert property (@(posedge mclk)
      !channel_reset[1] |-> !wave_clear[1])
      else $error("counters held clear without reset");

   AST_START_PULSE: assert property (@(posedge mclk) disable iff (rst)
      ce && wave_start[0] && !any_sync[0] |=> !wave_start[0] || any_sync[0])
      else $error("unsynced start longer than a cycle");

   AST_NOSYNC_START: assert property (@(posedge mclk)
      wave_start[0] && !any_sync[0] |-> !allowed_q[0])
      else $error("unsynced start without resume");

   AST_EDGE_FALL: assert property (@(posedge mclk) disable iff (rst)
      ce && !edge_sel[1] && pad_fall[1] |=> flags[1])
      else $error("falling edge did not set flag");

   AST_UPPER_FALL: assert property (@(posedge mclk) disable iff (rst)
      ce && !edge_sel[9] && pad_fall[9] |=> flags[9])
      else $error("upper falling edge did not set flag");

   AST_TYPE_BLOCK: assert property (@(posedge mclk)
      source_type[0] && !wave_done[0] |-> !notify_evt[0])
      else $error("pad edge notified while type set");

   AST_EDGE_ONLY: assert property (@(posedge mclk)
      !source_type[0] && !edge_evt[0] |-> !notify_evt[0])
      else $error("completion notified while type clear");

   AST_FLAG_HOLD: assert property (@(posedge mclk) disable iff (rst)
      ce && flags[1] && !clr_mask[1] |=> flags[1])
      else $error("flag lost without clear");

   AST_NO_SPURIOUS: assert property (@(posedge mclk) disable iff (rst)
      ce && !flags[1] && !notify_evt[1] |=> !flags[1])
      else $error("flag set without event");

   AST_WAKE_MASKED: assert property (@(posedge mclk)
      (flags & ~mask) == 12'h000 |-> !wake_irq)
      else $error("wake while all flags masked");

   AST_WAKE_PAD1: assert property (@(posedge mclk)
      flags[1] && !mask[1] |-> wake_irq)
      else $error("wake missing for pad one");

   AST_READ_IDLE: assert property (@(posedge mclk)
      !avs_read && !avs_write |-> !avs_waitrequest)
      else $error("waitrequest without request");

   AST_WAIT_FIRST: assert property (@(posedge mclk)
      ce && req && !ack |-> avs_waitrequest)
      else $error("first bus cycle not stalled");

   AST_WAIT_DROP: assert property (@(posedge mclk) disable iff (rst)
      ce && req && !ack |=> !avs_waitrequest || !req)
      else $error("bus stalled past one wait cycle");
endmodule : gpio_waveform_notify_ctrl

// ### testbench/wave_gen_model.sv
// behavioural waveform generator standing beside the control block
`timescale 1ns/100ps
module wave_gen_model #(
   parameter int SUBS = 2, // subperiods in one period
   parameter int TICKS = 3 // pace ticks in each subperiod
) (
   input wire logic mclk, // unit clock
   input wire logic rst, // synchronous reset
   input wire logic [7:0] pad_tick, // pace tick per pad
   input wire logic [7:0] wave_run, // pad may generate
   input wire logic [7:0] wave_start, // restart pulse
   input wire logic [7:0] wave_clear, // counters held clear
   output logic [7:0] wave_done // end of one period
);
   logic [7:0] busy;
   logic [7:0] cnt [8];
   // one period of equal subperiods, counted only on pace ticks
   always_ff @(posedge mclk) begin
      for (int i = 0; i < 8; i++) begin
         wave_done[i] <= 1'b0;
         if (rst || wave_clear[i]) begin
            busy[i] <= 1'b0;
            cnt[i] <= 8'h00;
         end else if (wave_start[i]) begin
            busy[i] <= 1'b1;
            cnt[i] <= 8'h00;
         end else if (busy[i] && wave_run[i] && pad_tick[i]) begin
            if (cnt[i] == 8'(SUBS * TICKS - 1)) begin
               busy[i] <= 1'b0;
               wave_done[i] <= 1'b1;
            end else begin
               cnt[i] <= cnt[i] + 8'h01;
            end
         end
      end
   end
endmodule : wave_gen_model

// ### testbench/gpio_waveform_notify_ctrl_tb.sv
// self-checking bench: registers, pace dividers, start control, notifications
`timescale 1ns/100ps
module gpio_waveform_notify_ctrl_tb;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [12:0] avs_address = 13'h0000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [3:0] avs_byteenable = 4'h1;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic frame_valid = 1'b1;
   logic flash_strobe = 1'b0;
   logic [11:0] pad_in = 12'h000;
   logic [7:0] wave_done, pad_tick, wave_run, wave_start, wave_clear;
   logic [1:0] pace_tick;
   logic [1:0] pace_clk;
   logic wake_irq;
   logic [16:0] snap;
   logic [31:0] rdv;
   int errors = 0;
   int checks_done = 0;
   int starts = 0;
   // register indices, reset values and stored bits, in one order
   logic [12:0] ra [14] = '{wave_notify_pkg::IDX_PAIR_CONFIG, wave_notify_pkg::IDX_CLOCK_DIVIDER,
      wave_notify_pkg::IDX_DIVIDER_SELECT, wave_notify_pkg::IDX_FRAME_END_SYNC,
      wave_notify_pkg::IDX_CHANNEL_RESET, wave_notify_pkg::IDX_CHANNEL_SUSPEND,
      wave_notify_pkg::IDX_SOURCE_TYPE, wave_notify_pkg::IDX_EDGE_UPPER,
      wave_notify_pkg::IDX_EDGE_LOWER, wave_notify_pkg::IDX_MASK_UPPER,
      wave_notify_pkg::IDX_MASK_LOWER, wave_notify_pkg::IDX_STROBE_SYNC,
      wave_notify_pkg::IDX_FLAGS_UPPER, wave_notify_pkg::IDX_FLAGS_LOWER};
   logic [7:0] rv [14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h0f, 8'hff, 8'h00, 8'h00, 8'h00};
   logic [7:0] rw [12] = '{8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h0f, 8'hff,
      8'h0f, 8'hff, 8'hff};

   always #2.5 mclk = ~mclk;

   gpio_waveform_notify_ctrl gpio_waveform_notify_ctrl_inst (.mclk(mclk), .rst(rst), .ce(1'b1),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .frame_valid(frame_valid), .flash_strobe(flash_strobe), .pad_in(pad_in),
      .wave_done(wave_done), .pace_tick(pace_tick), .pace_clk(pace_clk), .pad_tick(pad_tick),
      .wave_run(wave_run), .wave_start(wave_start), .wave_clear(wave_clear),
      .wake_irq(wake_irq));

   wave_gen_model wave_gen_model_inst (.mclk(mclk), .rst(rst), .pad_tick(pad_tick),
      .wave_run(wave_run), .wave_start(wave_start), .wave_clear(wave_clear),
      .wave_done(wave_done));

   // outputs sampled away from the active edge; restarts of pad 0 counted
   always @(negedge mclk) begin
      snap = {wake_irq, wave_clear, wave_run};
      if (wave_start[0] === 1'b1) starts++;
   end

   task automatic conclude;
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one bus transfer, held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [12:0] a, input logic [7:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_write <= wr;
      avs_read <= ~wr;
      do begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rdv = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         errors++;
         conclude();
      end
      @(posedge mclk);
   endtask : bus

   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [12:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      chk(rdv, {24'h000000, exp});
   endtask : rd

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask : cyc

   // cycles between two ticks of one divider
   task automatic gap_chk(input int b, input int exp);
      int g;
      int n;
      g = 0;
      n = 0;
      @(negedge mclk);
      while (pace_tick[b] !== 1'b1 && n < 300) begin
         @(negedge mclk);
         n++;
      end
      do begin
         @(negedge mclk);
         g++;
      end while (pace_tick[b] !== 1'b1 && g < 300);
      chk(g, exp);
      @(posedge mclk);
   endtask : gap_chk

   // sync restart of pad 0: only the chosen pin edge restarts after resume
   task automatic sync_run(input int k, input logic frm);
      int s;
      wr(ra[5], 8'h01);
      wr(ra[k], 8'h01);
      wr(ra[5], 8'h00);
      s = starts;
      cyc(8);
      chk(starts - s, 0);
      for (int j = 1; j <= 2; j++) begin
         {frame_valid, flash_strobe} <= frm ? 2'b00 : 2'b11;
         cyc(8);
         chk(starts - s, j);
         {frame_valid, flash_strobe} <= 2'b10;
         cyc(8);
         chk(starts - s, j);
      end
      wr(ra[k], 8'h00);
   endtask : sync_run

   initial begin
      repeat (100000) @(posedge mclk);
      errors++;
      conclude();
   end

   initial begin
      int s;
      int n_ok;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      for (int k = 0; k < 14; k++) rd(ra[k], rv[k]);
      for (int k = 0; k < 12; k++) begin
         wr(ra[k], 8'h5a);
         rd(ra[k], 8'h5a & rw[k]);
         wr(ra[k], rv[k]);
      end
      wr(13'h10b7, 8'hff);
      rd(13'h10b7, 8'h00);
      avs_byteenable <= 4'h0;
      wr(ra[2], 8'hff);
      avs_byteenable <= 4'h1;
      rd(ra[2], 8'h00);
      // dividers and per-pad selection
      wr(ra[1], 8'h21);
      gap_chk(0, 4);
      gap_chk(1, 8);
      // square pace clocks: half of each period high
      n_ok = 0;
      s = 0;
      for (int j = 0; j < 8; j++) begin
         @(negedge mclk);
         n_ok += pace_clk[0];
         s += pace_clk[1];
      end
      chk(n_ok, 4);
      chk(s, 4);
      @(posedge mclk);
      wr(ra[2], 8'h01);
      n_ok = 0;
      for (int j = 0; j < 24; j++) begin
         @(negedge mclk);
         if (pad_tick[1:0] === {pace_tick[0], pace_tick[1]}) n_ok++;
      end
      chk(n_ok, 24);
      @(posedge mclk);
      // pair enable, suspend and channel reset
      s = starts;
      wr(ra[0], 8'h01);
      cyc(2);
      chk(starts - s, 1);
      chk(snap[1:0], 2'b11);
      wr(ra[5], 8'h01);
      chk(snap[0], 1'b0);
      s = starts;
      wr(ra[5], 8'h00);
      cyc(2);
      chk(starts - s, 1);
      chk(snap[0], 1'b1);
      wr(ra[4], 8'h01);
      chk({snap[8], snap[0]}, 2'b10);
      s = starts;
      wr(ra[4], 8'h00);
      cyc(2);
      chk(starts - s, 1);
      sync_run(3, 1'b1);
      sync_run(11, 1'b0);
      // edge notifications, mask and write-one-to-clear flags
      wr(ra[13], 8'hff);
      wr(ra[12], 8'h0f);
      wr(ra[8], 8'h01);
      wr(ra[10], 8'hfe);
      wr(ra[7], 8'h01);
      pad_in <= 12'h303;
      cyc(8);
      rd(ra[13], 8'h01);
      rd(ra[12], 8'h01);
      chk(snap[16], 1'b1);
      wr(ra[13], 8'h00);
      rd(ra[13], 8'h01);
      wr(ra[13], 8'h01);
      rd(ra[13], 8'h00);
      chk(snap[16], 1'b0);
      pad_in <= 12'h000;
      cyc(8);
      rd(ra[13], 8'h02);
      rd(ra[12], 8'h03);
      chk(snap[16], 1'b0);
      wr(ra[10], 8'hfc);
      chk(snap[16], 1'b1);
      wr(ra[13], 8'hff);
      // completion notification; pad edge ignored while type bit set
      wr(ra[6], 8'h01);
      pad_in <= 12'h001;
      wr(ra[5], 8'h01);
      wr(ra[5], 8'h00);
      cyc(20);
      rd(ra[13], 8'h00);
      cyc(60);
      rd(ra[13], 8'h01);
      conclude();
   end
endmodule : gpio_waveform_notify_ctrl_tb
